// ==== src/scd_defines.svh ====
// constants for the system clock source and divider block
// assumes one 250 MHz clock; high- and low-speed oscillators arrive as one-cycle tick enables, the main oscillator as a pin level
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH
`define SCD_RST_PIN_SEL 1'b0
`define SCD_RST_MOSC_STOP 1'b1
`define SCD_RST_FB_DIS 1'b0
`define SCD_RST_SRC_SEL 1'b1
`define SCD_RST_OCD 2'h0
`define SCD_RST_ONCHIP_SEL 1'b0
`define SCD_RST_HS_ON 1'b0
`define SCD_RST_PREDIV 3'h0
`define SCD_RST_DIV8 1'b0
`define SCD_RST_DIV_FIELD 2'h0
`define SCD_RST_OVERRIDE 1'b0
`define SCD_OCD_AUTO 2'h3
`define SCD_SRC_MAIN 1'b0
`define SCD_FIELD_DIV1 2'h0
`define SCD_FIELD_DIV2 2'h1
`define SCD_FIELD_DIV4 2'h2
`define SCD_RATIO_1 5'h01
`define SCD_RATIO_2 5'h02
`define SCD_RATIO_4 5'h04
`define SCD_RATIO_8 5'h08
`define SCD_RATIO_16 5'h10
`define SCD_PREDIV_BASE 4'h2
`define SCD_DIV128_RATIO 8'h80
`define SCD_LOSS_LIMIT 8
`define SCD_TRIM_DEFAULT 8'h80
`endif

// ==== src/scd_pkg.sv ====
// types shared by the clock source and divider block
// assumes the defines header sits beside it
package scd_pkg;
   // main oscillator control states
   typedef enum logic [1:0] {
      MOSC_OFF,
      MOSC_RUN,
      MOSC_FALLBACK
   } scd_mosc_state_type;

   // every flop of the top module
   typedef struct packed {
      logic pin_sel;
      logic mosc_stop;
      logic fb_dis;
      logic src_sel;
      logic [1:0] osc_stop_detect_reg;
      logic onchip_sel;
      logic hs_on;
      logic [2:0] prediv;
      logic div8;
      logic [1:0] div_field;
      logic override;
      logic [7:0] coarse;
      logic [7:0] fine;
      scd_mosc_state_type mosc;
      logic pin_prev;
      logic stop_prev;
      logic amp_en;
      logic amp_drive;
      logic fb_en;
      logic hs_en;
      logic ls_en;
      logic onchip_tick;
      logic fast_tick;
      logic slow_tick;
      logic src_main;
   } scd_top_state_type;
endpackage

// ==== src/scd_tick_div.sv ====
// tick divider: one output pulse per ratio input ticks
// assumes ticks are one-cycle enables; ratio is at least one
module scd_tick_div #(
   parameter int W = 5
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic tick_in,
   input wire logic [W-1:0] ratio_in,
   output logic pulse_out
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] ratio;
      logic pulse;
   } scd_div_state_type;

   scd_div_state_type st_q, st_d;

   // ratio only taken at a pulse boundary, so no period is cut short
   always_comb begin
      st_d = st_q;
      st_d.pulse = 1'b0;
      if (tick_in) begin
         if (st_q.cnt + W'(1) >= st_q.ratio) begin
            st_d.pulse = 1'b1;
            st_d.cnt = '0;
            st_d.ratio = ratio_in;
         end else begin
            st_d.cnt = st_q.cnt + W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pulse_out = st_q.pulse;

   chk_pulse_has_tick: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      pulse_out |-> $past(tick_in))
      else $error("divider pulse without a source tick");
endmodule

// ==== src/scd_loss_det.sv ====
// main oscillator loss detector referenced to the low-speed ticks
// assumes both tick inputs are one-cycle enables on sys_clk_in
`include "scd_defines.svh"
module scd_loss_det #(
   parameter int LIMIT = `SCD_LOSS_LIMIT
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic enable_in,
   input wire logic main_tick_in,
   input wire logic ref_tick_in,
   output logic lost_out
);
   typedef struct packed {
      logic [7:0] cnt;
      logic lost;
   } scd_loss_state_type;

   scd_loss_state_type st_q, st_d;

   // any main edge restarts the count; reference ticks age it
   always_comb begin
      st_d = st_q;
      if (!enable_in || main_tick_in) begin
         st_d.cnt = '0;
         st_d.lost = 1'b0;
      end else if (ref_tick_in && !st_q.lost) begin
         st_d.cnt = st_q.cnt + 8'h01;
         st_d.lost = (st_q.cnt + 8'h01) >= 8'(LIMIT);
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign lost_out = st_q.lost;

   chk_edge_clears_loss: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (enable_in && main_tick_in) |=> !lost_out)
      else $error("loss flag held after a main edge");
endmodule

// ==== src/scd_top.sv ====
// clock source selection, main oscillator control and cpu divider
// assumes oscillators deliver synchronous ticks; software bits arrive
// with a single write strobe and are held here
`include "scd_defines.svh"
module scd_top #(
   parameter int LOSS_LIMIT = `SCD_LOSS_LIMIT,
   parameter logic [7:0] COARSE_RST = `SCD_TRIM_DEFAULT,
   parameter logic [7:0] FINE_RST = `SCD_TRIM_DEFAULT
) (
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic cfg_wr_in,
   input wire logic main_pin_select_in,
   input wire logic main_osc_stop_in,
   input wire logic feedback_resistor_disable_in,
   input wire logic system_source_select_in,
   input wire logic osc_stop_detect_hi_in,
   input wire logic osc_stop_detect_lo_in,
   input wire logic onchip_osc_select_in,
   input wire logic hs_osc_on_in,
   input wire logic [2:0] hs_prediv_in,
   input wire logic cpu_div8_select_in,
   input wire logic cpu_div_field_hi_in,
   input wire logic cpu_div_field_lo_in,
   input wire logic stop_div_override_in,
   input wire logic [7:0] hs_coarse_trim_in,
   input wire logic [7:0] hs_fine_trim_in,
   input wire logic stop_mode_in,
   input wire logic main_osc_in_pin_in,
   input wire logic hs_osc_tick_in,
   input wire logic ls_osc_tick_in,
   output logic main_osc_out_pin_out,
   output logic main_osc_out_pin_oe_out,
   output logic main_osc_run_out,
   output logic feedback_resistor_en_out,
   output logic hs_osc_enable_out,
   output logic ls_osc_enable_out,
   output logic [7:0] hs_coarse_trim_out,
   output logic [7:0] hs_fine_trim_out,
   output logic cpu_clk_en_out,
   output logic wdt_clk_en_out,
   output logic onchip_periph_clk_out,
   output logic fast_undivided_tap_out,
   output logic fast_divided_tap_out,
   output logic slow_onchip_tap_out,
   output logic div128_tap_out,
   output logic cpu_div8_select_out,
   output logic system_source_out,
   output logic osc_lost_out,
   output logic fallback_active_out
);
   import scd_pkg::*;

   scd_top_state_type st_q, st_d;
   logic main_tick;
   logic ls_tick;
   logic hs_tick;
   logic prediv_pulse;
   logic onchip_tick;
   logic sys_tick;
   logic lost;
   logic cpu_pulse;
   logic slow128_pulse;
   logic stop_entry;
   logic [3:0] prediv_ratio;
   logic [4:0] cpu_ratio;

   // cpu ratio decode: divide-by-8 bit overrides the two-bit field
   function automatic logic [4:0] cpu_ratio_of(input logic div8,
                                               input logic [1:0] field);
      logic [4:0] r;
      r = `SCD_RATIO_16;
      if (div8) begin
         r = `SCD_RATIO_8;
      end else begin
         case (field)
            `SCD_FIELD_DIV1: r = `SCD_RATIO_1;
            `SCD_FIELD_DIV2: r = `SCD_RATIO_2;
            `SCD_FIELD_DIV4: r = `SCD_RATIO_4;
            default: r = `SCD_RATIO_16;
         endcase
      end
      return r;
   endfunction

   // oscillator ticks; nothing runs while the chip is in stop mode
   assign main_tick = main_osc_in_pin_in && !st_q.pin_prev
      && st_q.amp_en && !stop_mode_in;
   assign ls_tick = ls_osc_tick_in && !stop_mode_in;
   assign hs_tick = hs_osc_tick_in && st_q.hs_on && !stop_mode_in;
   assign stop_entry = stop_mode_in && !st_q.stop_prev;

   // every pattern is legal: ratio is the pattern plus two
   assign prediv_ratio = {1'b0, st_q.prediv} + `SCD_PREDIV_BASE;

   // on-chip clock: high-speed only when selected and switched on
   assign onchip_tick = (st_q.onchip_sel && st_q.hs_on && st_q.mosc != MOSC_FALLBACK)
      ? prediv_pulse : ls_tick;

   // pulses are whole ticks, so a source swap cannot slice one
   assign sys_tick = st_q.src_main ? main_tick : onchip_tick;

   assign cpu_ratio = cpu_ratio_of(st_q.div8, st_q.div_field);

   scd_tick_div #(
      .W(4)
   ) u_prediv (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tick_in(hs_tick),
      .ratio_in(prediv_ratio),
      .pulse_out(prediv_pulse)
   );

   // one divider feeds both cpu and watchdog
   scd_tick_div #(
      .W(5)
   ) u_cpudiv (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tick_in(sys_tick),
      .ratio_in(cpu_ratio),
      .pulse_out(cpu_pulse)
   );

   scd_tick_div #(
      .W(8)
   ) u_div128 (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .tick_in(ls_tick),
      .ratio_in(`SCD_DIV128_RATIO),
      .pulse_out(slow128_pulse)
   );

   scd_loss_det #(
      .LIMIT(LOSS_LIMIT)
   ) u_loss (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .enable_in(st_q.amp_en && !stop_mode_in),
      .main_tick_in(main_tick),
      .ref_tick_in(ls_tick),
      .lost_out(lost)
   );

   // next state: software writes, oscillator control, tap registers
   always_comb begin
      st_d = st_q;
      st_d.pin_prev = main_osc_in_pin_in;
      st_d.stop_prev = stop_mode_in;
      if (cfg_wr_in) begin
         st_d.pin_sel = main_pin_select_in;
         st_d.mosc_stop = main_osc_stop_in;
         st_d.fb_dis = feedback_resistor_disable_in;
         st_d.src_sel = system_source_select_in;
         st_d.osc_stop_detect_reg = {osc_stop_detect_hi_in, osc_stop_detect_lo_in};
         st_d.onchip_sel = onchip_osc_select_in;
         st_d.hs_on = hs_osc_on_in;
         st_d.prediv = hs_prediv_in;
         st_d.div8 = cpu_div8_select_in;
         st_d.div_field = {cpu_div_field_hi_in, cpu_div_field_lo_in};
         st_d.override = stop_div_override_in;
         st_d.coarse = hs_coarse_trim_in;
         st_d.fine = hs_fine_trim_in;
      end
      // stop entry wins over a software write in the same cycle
      if (stop_entry && !st_q.override) begin
         st_d.div8 = 1'b1;
      end
      // main oscillator control
      case (st_q.mosc)
         MOSC_OFF: begin
            if (st_q.pin_sel && !st_q.mosc_stop) begin
               st_d.mosc = MOSC_RUN;
            end
         end
         MOSC_RUN: begin
            if (!st_q.pin_sel || (st_q.mosc_stop && st_q.src_sel)) begin
               st_d.mosc = MOSC_OFF;
            end else if (lost && st_q.osc_stop_detect_reg == `SCD_OCD_AUTO) begin
               st_d.mosc = MOSC_FALLBACK;
            end
         end
         MOSC_FALLBACK: begin
            if (!st_q.pin_sel || (st_q.mosc_stop && st_q.src_sel)) begin
               st_d.mosc = MOSC_OFF;
            end else if (!lost && st_q.osc_stop_detect_reg != `SCD_OCD_AUTO) begin
               st_d.mosc = MOSC_RUN;
            end
         end
         default: begin
            st_d.mosc = MOSC_OFF;
         end
      endcase
      // amplifier keeps trying during fallback so a restart is seen
      st_d.amp_en = (st_d.mosc != MOSC_OFF) && !stop_mode_in;
      st_d.amp_drive = st_d.amp_en && !main_osc_in_pin_in;
      st_d.fb_en = st_d.amp_en && !st_q.fb_dis;
      st_d.hs_en = st_q.hs_on && !stop_mode_in;
      st_d.ls_en = !stop_mode_in;
      st_d.src_main = (st_q.src_sel == `SCD_SRC_MAIN)
         && (st_d.mosc == MOSC_RUN);
      st_d.onchip_tick = onchip_tick;
      st_d.fast_tick = hs_tick;
      st_d.slow_tick = ls_tick;
   end

   // single synchronous reset holds the documented start-up values
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         st_q <= '0;
         st_q.pin_sel <= `SCD_RST_PIN_SEL;
         st_q.mosc_stop <= `SCD_RST_MOSC_STOP;
         st_q.fb_dis <= `SCD_RST_FB_DIS;
         st_q.src_sel <= `SCD_RST_SRC_SEL;
         st_q.osc_stop_detect_reg <= `SCD_RST_OCD;
         st_q.onchip_sel <= `SCD_RST_ONCHIP_SEL;
         st_q.hs_on <= `SCD_RST_HS_ON;
         st_q.prediv <= `SCD_RST_PREDIV;
         st_q.div8 <= `SCD_RST_DIV8;
         st_q.div_field <= `SCD_RST_DIV_FIELD;
         st_q.override <= `SCD_RST_OVERRIDE;
         st_q.coarse <= COARSE_RST;
         st_q.fine <= FINE_RST;
         st_q.mosc <= MOSC_OFF;
         st_q.ls_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs from the state flops (system source inverted, fallback decoded from the oscillator state), the divider flops or the loss detector flop
   assign main_osc_out_pin_out = st_q.amp_drive;
   assign main_osc_out_pin_oe_out = st_q.amp_en;
   assign main_osc_run_out = st_q.amp_en;
   assign feedback_resistor_en_out = st_q.fb_en;
   assign hs_osc_enable_out = st_q.hs_en;
   assign ls_osc_enable_out = st_q.ls_en;
   assign hs_coarse_trim_out = st_q.coarse;
   assign hs_fine_trim_out = st_q.fine;
   assign cpu_clk_en_out = cpu_pulse;
   assign wdt_clk_en_out = cpu_pulse;
   assign onchip_periph_clk_out = st_q.onchip_tick;
   assign fast_undivided_tap_out = st_q.fast_tick;
   assign fast_divided_tap_out = prediv_pulse;
   assign slow_onchip_tap_out = st_q.slow_tick;
   assign div128_tap_out = slow128_pulse;
   assign cpu_div8_select_out = st_q.div8;
   assign system_source_out = !st_q.src_main;
   assign osc_lost_out = lost;
   assign fallback_active_out = (st_q.mosc == MOSC_FALLBACK);

   // main never leaves the off state without pin select and a cleared stop bit; a stop-mode exit can restart it with the stop bit set
   chk_main_needs_enable: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $rose(main_osc_run_out) |-> ($past(st_q.pin_sel) && !$past(st_q.mosc_stop)))
      else $error("main oscillator started without enable");

   chk_main_stop_onchip: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (st_q.mosc != MOSC_OFF && st_q.mosc_stop && st_q.src_sel) |=> !main_osc_run_out)
      else $error("main oscillator kept running after stop");

   chk_stop_mode_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (stop_mode_in && $past(stop_mode_in)) |=> (!cpu_clk_en_out
         && !feedback_resistor_en_out && !main_osc_run_out))
      else $error("clock activity in stop mode");

   chk_feedback_disable: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      st_q.fb_dis |=> !feedback_resistor_en_out)
      else $error("feedback resistor on while disabled");

   chk_reset_values: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      $past(reset_in) |-> (!hs_osc_enable_out && !cpu_div8_select_out
         && system_source_out && cpu_ratio == `SCD_RATIO_1))
      else $error("wrong clock setup after reset");

   chk_div8_on_stop: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (stop_entry && !st_q.override) |=> cpu_div8_select_out)
      else $error("divide-by-8 not forced on stop entry");

   chk_fallback_entry: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      (st_q.mosc == MOSC_RUN && lost && st_q.osc_stop_detect_reg == `SCD_OCD_AUTO && st_q.pin_sel
         && !(st_q.mosc_stop && st_q.src_sel)) |=> (fallback_active_out ##1 !st_q.src_main))
      else $error("no fallback after main loss");

   chk_hs_off_quiet: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      !st_q.hs_on |=> !fast_undivided_tap_out)
      else $error("high-speed tap active while off");

   chk_div8_ratio: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      st_q.div8 |-> cpu_ratio == `SCD_RATIO_8)
      else $error("divide-by-8 bit not honoured");

   chk_prediv_ratio: assert property (@(posedge sys_clk_in) disable iff (reset_in)
      st_q.prediv == 3'h7 |-> prediv_ratio == 4'h9)
      else $error("pre-divider top pattern not nine");
endmodule

// ==== bench/scd_xtal_model.sv ====
// crystal resonator model driving the main oscillator input pin
// assumes the bench clock; half period is counted in bench clock cycles
module scd_xtal_model (
   input wire logic sys_clk_in,
   input wire logic amp_on_in,
   input wire logic kill_in,
   input wire logic [3:0] half_in,
   output logic pin_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt_q;
   initial begin
      pin_out = 1'b0;
      cnt_q = 4'h0;
   end
   // swings every half_in cycles while the amplifier drives it and kill_in is low, holds while killed, every cycle while undriven
   always @(posedge sys_clk_in) begin
      if (!amp_on_in) begin
         // undriven pin toggles so a stale level never looks like a clock stop
         pin_out <= ~pin_out;
         cnt_q <= 4'h0;
      end else if (kill_in) begin
         cnt_q <= 4'h0;
      end else if (cnt_q >= half_in - 4'h1) begin
         pin_out <= ~pin_out;
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_q + 4'h1;
      end
   end
endmodule

// ==== bench/testbench.sv ====
// self-checking bench for the clock source and divider top
// assumes scd_pkg, scd_top and the resonator model are compiled first
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import scd_pkg::*;
   localparam int LS_P = 3;
   localparam int HS_P = 2;
   // trim reset and stored correction bytes: arbitrary values
   localparam logic [7:0] TRIM_C = 8'h11;
   localparam logic [7:0] TRIM_F = 8'h22;
   localparam logic [7:0] ALT_C = 8'h5A;
   localparam logic [7:0] ALT_F = 8'hA5;
   localparam logic [7:0] LOW_C = 8'h3C;
   localparam logic [7:0] LOW_F = 8'hC3;
   typedef struct packed {
      logic pin, stop, fbd, src;
      logic [1:0] osc_stop_detect_reg;
      logic onsel, hson;
      logic [2:0] pre;
      logic div8;
      logic [1:0] fld;
      logic ovr;
      logic [7:0] coarse, fine;
   } scd_tb_cfg_type;
   typedef struct packed {
      logic div8;
      logic [1:0] fld;
      logic [2:0] pre;
      logic [4:0] ratio;
   } scd_tb_row_type;
   localparam scd_tb_cfg_type CFG_RST = '{1'b0, 1'b1, 1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 3'h0,
      1'b0, 2'h0, 1'b0, 8'h00, 8'h00};
   // every prediv pattern, every cpu divider setting, div8 over a nonzero field
   scd_tb_row_type rows [8] = '{'{1'b0, 2'h0, 3'h0, 5'h01}, '{1'b0, 2'h1, 3'h1, 5'h02},
      '{1'b0, 2'h2, 3'h2, 5'h04}, '{1'b0, 2'h3, 3'h3, 5'h10}, '{1'b1, 2'h0, 3'h4, 5'h08},
      '{1'b1, 2'h3, 3'h5, 5'h08}, '{1'b0, 2'h0, 3'h6, 5'h01}, '{1'b0, 2'h2, 3'h7, 5'h04}};
   logic sys_clk_in, reset_in, cfg_wr_in, stop_mode_in, ls_tick, hs_tick, kill, pin;
   logic out_pin, out_oe, run, fb_en, hs_en, ls_en, cpu_en, wdt_en, periph, fast_u, fast_d;
   logic slow, d128, div8_o, src_o, lost, fb_act;
   logic [7:0] co_o, fi_o;
   logic [3:0] half;
   scd_tb_cfg_type cfg_q, c;
   int n_fail = 0;
   int checks_done = 0;
   int ls_cnt = 0;
   int hs_cnt = 0;
   int n, m, k;

   scd_top #(.LOSS_LIMIT(2), .COARSE_RST(TRIM_C), .FINE_RST(TRIM_F)) DUT (
      .sys_clk_in(sys_clk_in), .reset_in(reset_in), .cfg_wr_in(cfg_wr_in),
      .main_pin_select_in(cfg_q.pin), .main_osc_stop_in(cfg_q.stop),
      .feedback_resistor_disable_in(cfg_q.fbd), .system_source_select_in(cfg_q.src),
      .osc_stop_detect_hi_in(cfg_q.osc_stop_detect_reg[1]), .osc_stop_detect_lo_in(cfg_q.osc_stop_detect_reg[0]),
      .onchip_osc_select_in(cfg_q.onsel), .hs_osc_on_in(cfg_q.hson), .hs_prediv_in(cfg_q.pre),
      .cpu_div8_select_in(cfg_q.div8), .cpu_div_field_hi_in(cfg_q.fld[1]),
      .cpu_div_field_lo_in(cfg_q.fld[0]), .stop_div_override_in(cfg_q.ovr),
      .hs_coarse_trim_in(cfg_q.coarse), .hs_fine_trim_in(cfg_q.fine),
      .stop_mode_in(stop_mode_in), .main_osc_in_pin_in(pin), .hs_osc_tick_in(hs_tick),
      .ls_osc_tick_in(ls_tick), .main_osc_out_pin_out(out_pin), .main_osc_out_pin_oe_out(out_oe),
      .main_osc_run_out(run), .feedback_resistor_en_out(fb_en), .hs_osc_enable_out(hs_en),
      .ls_osc_enable_out(ls_en), .hs_coarse_trim_out(co_o), .hs_fine_trim_out(fi_o),
      .cpu_clk_en_out(cpu_en), .wdt_clk_en_out(wdt_en), .onchip_periph_clk_out(periph),
      .fast_undivided_tap_out(fast_u), .fast_divided_tap_out(fast_d),
      .slow_onchip_tap_out(slow), .div128_tap_out(d128), .cpu_div8_select_out(div8_o),
      .system_source_out(src_o), .osc_lost_out(lost), .fallback_active_out(fb_act));

   scd_xtal_model xtal (.sys_clk_in(sys_clk_in), .amp_on_in(run), .kill_in(kill),
      .half_in(half), .pin_out(pin));

   // 250 MHz system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end

   // oscillator ticks; periods kept short so long ratios stay cheap
   always @(posedge sys_clk_in) begin
      ls_cnt <= (ls_cnt == LS_P - 1) ? 0 : ls_cnt + 1;
      hs_cnt <= (hs_cnt == HS_P - 1) ? 0 : hs_cnt + 1;
      ls_tick <= (ls_cnt == LS_P - 1);
      hs_tick <= (hs_cnt == HS_P - 1);
   end

   task automatic step();
      @(posedge sys_clk_in);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input scd_tb_cfg_type v);
      @(posedge sys_clk_in);
      cfg_q <= v;
      cfg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      cfg_wr_in <= 1'b0;
      #1;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return cpu_en;
         1: return fast_d;
         2: return d128;
         3: return periph;
         default: return fast_u;
      endcase
   endfunction

   // cycles from one pulse of the chosen output to the next, bounded
   task automatic gap(input int sel, output int g);
      int t;
      t = 0;
      while (pick(sel) !== 1'b1 && t < 400) begin
         step();
         t++;
      end
      if (sel == 0) chk(wdt_en, 1'b1);
      g = 1;
      step();
      while (pick(sel) !== 1'b1 && g < 400) begin
         step();
         g++;
      end
   endtask

   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog: whole run needs well under 20000 cycles
   initial begin
      repeat (40000) @(posedge sys_clk_in);
      n_fail++;
      summarize();
   end

   initial begin
      reset_in = 1'b1;
      cfg_wr_in = 1'b0;
      stop_mode_in = 1'b0;
      kill = 1'b0;
      half = 4'h2;
      ls_tick = 1'b0;
      hs_tick = 1'b0;
      cfg_q = CFG_RST;
      c = CFG_RST;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      step();
      step();
      chk(run, 1'b0);
      chk(hs_en, 1'b0);
      chk(ls_en, 1'b1);
      chk(src_o, 1'b1);
      chk({co_o, fi_o}, {TRIM_C, TRIM_F});
      gap(0, n);
      chk(n, LS_P);
      // stop cleared without the pin select must not start the oscillator
      c.stop = 1'b0;
      wr(c);
      repeat (4) step();
      chk(run, 1'b0);
      $display("test reset done");
      c.onsel = 1'b1;
      c.hson = 1'b1;
      wr(c);
      step();
      chk(hs_en, 1'b1);
      gap(4, n);
      chk(n, HS_P);
      foreach (rows[i]) begin
         m = (rows[i].pre + 2) * HS_P;
         c.div8 = rows[i].div8;
         c.fld = rows[i].fld;
         c.pre = rows[i].pre;
         wr(c);
         gap(1, n);
         gap(1, n);
         chk(n, m);
         gap(0, n);
         gap(0, n);
         chk(n, m * rows[i].ratio);
      end
      $display("test ratios done");
      c.div8 = 1'b0;
      c.fld = 2'h0;
      c.pin = 1'b1;
      c.stop = 1'b1;
      wr(c);
      c.stop = 1'b0;
      wr(c);
      step();
      chk({run, out_oe, fb_en}, 3'h7);
      // source switched only once the oscillation has settled
      repeat (20) step();
      // drive pin follows the inverted input: half of a steady period
      m = 0;
      for (k = 0; k < 8; k++) begin
         step();
         m += out_pin;
      end
      chk(m, 4);
      c.src = 1'b0;
      wr(c);
      step();
      chk(src_o, 1'b0);
      gap(0, n);
      gap(0, n);
      chk(n, 4);
      half = 4'h5;
      gap(0, n);
      gap(0, n);
      chk(n, 10);
      half = 4'h2;
      c.fbd = 1'b1;
      wr(c);
      step();
      chk(fb_en, 1'b0);
      c.fbd = 1'b0;
      c.stop = 1'b1;
      wr(c);
      repeat (3) step();
      chk(run, 1'b1);
      c.src = 1'b1;
      wr(c);
      step();
      chk({run, out_oe, out_pin}, 3'h0);
      $display("test main done");
      c.stop = 1'b0;
      wr(c);
      repeat (20) step();
      // detection armed only once the oscillation has settled
      c.src = 1'b0;
      c.osc_stop_detect_reg = 2'h3;
      wr(c);
      step();
      chk(src_o, 1'b0);
      @(posedge sys_clk_in);
      kill <= 1'b1;
      for (k = 0; k < 60 && fb_act !== 1'b1; k++) step();
      chk({fb_act, lost, src_o}, 3'h7);
      chk(k >= LS_P, 1'b1);
      gap(0, n);
      gap(0, n);
      chk(n, LS_P);
      $display("test fallback done");
      @(posedge sys_clk_in);
      kill <= 1'b0;
      c.src = 1'b1;
      c.osc_stop_detect_reg = 2'h0;
      c.hson = 1'b0;
      c.onsel = 1'b0;
      c.coarse = ALT_C;
      c.fine = ALT_F;
      wr(c);
      step();
      chk({co_o, fi_o}, {ALT_C, ALT_F});
      c.coarse = LOW_C;
      c.fine = LOW_F;
      wr(c);
      step();
      chk({co_o, fi_o}, {LOW_C, LOW_F});
      $display("test trim done");
      // override already 0 before stop entry
      @(posedge sys_clk_in);
      stop_mode_in <= 1'b1;
      step();
      step();
      chk({div8_o, fb_en}, 2'h2);
      m = 0;
      for (k = 0; k < 40; k++) begin
         step();
         if (cpu_en !== 1'b0 || slow !== 1'b0 || fast_u !== 1'b0
            || periph !== 1'b0 || d128 !== 1'b0) m++;
      end
      chk(m, 0);
      @(posedge sys_clk_in);
      stop_mode_in <= 1'b0;
      gap(0, n);
      gap(0, n);
      chk(n, 8 * LS_P);
      // override set: stop entry must leave the divider setting alone
      c.ovr = 1'b1;
      wr(c);
      @(posedge sys_clk_in);
      stop_mode_in <= 1'b1;
      step();
      step();
      chk(div8_o, 1'b0);
      @(posedge sys_clk_in);
      stop_mode_in <= 1'b0;
      $display("test stop done");
      @(posedge sys_clk_in);
      reset_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      step();
      step();
      chk({run, div8_o, src_o}, 3'h1);
      gap(0, n);
      gap(0, n);
      chk(n, LS_P);
      gap(3, n);
      chk(n, LS_P);
      gap(2, n);
      chk(n, 128 * LS_P);
      $display("test second reset done");
      summarize();
   end
endmodule
